// ==== src/aem_master.sv ====
// Purpose: Half-duplex serial master for an absolute position encoder
// Assumes: Line input already synchronous to i_sys_clk
// Notes:   Response payloads are read back through i_rd_idx/o_rd_data
`timescale 1ns/1ps
module aem_master (
   input  wire logic        i_sys_clk,
   input  wire logic        i_rst,
   input  wire logic        i_start,
   input  wire logic [3:0]  i_ident,
   input  wire logic [7:0]  i_mem_addr,
   input  wire logic [7:0]  i_mem_data,
   input  wire logic [15:0] i_timeout_cyc,
   input  wire logic [3:0]  i_rd_idx,
   input  wire logic        i_line_data,
   output logic             o_line_data,
   output logic             o_line_dir_enable,
   output logic             o_generated_shift_clock,
   output logic             o_busy,
   output logic             o_done,
   output logic             o_crc_err,
   output logic             o_echo_err,
   output logic             o_timeout_err,
   output logic [3:0]       o_field_cnt,
   output logic [15:0]      o_prop_delay,
   output logic [7:0]       o_rd_data
);
   // Fold one payload byte into the checksum, least significant bit first
   function automatic logic [7:0] crc_byte(input logic [7:0] crc,
                                           input logic [7:0] data);
      logic [7:0] c;
      logic       fb;
      c = crc;
      for (int i = 0; i < 8; i++) begin
         fb = c[7] ^ data[i];
         c  = {c[6:0], 1'b0} ^ (fb ? aem_pkg::CRC_POLY : 8'h00);
      end
      return c;
   endfunction

   // Build the control field payload for an identifier
   function automatic logic [7:0] ctrl_field(input logic [3:0] id);
      return {^id, id, aem_pkg::CTRL_SYNC};
   endfunction

   // Response length in fields, checksum included
   function automatic logic [3:0] rsp_len(input logic [3:0] id);
      case (id)
         aem_pkg::ID_IDENT:  return aem_pkg::RSP_LEN_IDENT;
         aem_pkg::ID_ALL:    return aem_pkg::RSP_LEN_ALL;
         aem_pkg::ID_MEM_WR,
         aem_pkg::ID_MEM_RD: return aem_pkg::RSP_LEN_MEM;
         default:            return aem_pkg::RSP_LEN_ABS;
      endcase
   endfunction

   // Request length in fields
   function automatic logic [3:0] req_len(input logic [3:0] id);
      case (id)
         aem_pkg::ID_MEM_RD: return aem_pkg::REQ_LEN_RD;
         aem_pkg::ID_MEM_WR: return aem_pkg::REQ_LEN_WR;
         default:            return aem_pkg::REQ_LEN_CTRL;
      endcase
   endfunction

   aem_pkg::aem_phase_t state_r, state_nxt;
   logic [6:0]  cnt_r, cnt_nxt;
   logic [3:0]  bit_r, bit_nxt;
   logic [3:0]  fld_r, fld_nxt;
   logic [3:0]  len_r, len_nxt;
   logic [3:0]  rlen_r, rlen_nxt;
   logic [7:0]  f0_r, f0_nxt;
   logic [7:0]  f1_r, f1_nxt;
   logic [7:0]  f2_r, f2_nxt;
   logic [7:0]  f3_r, f3_nxt;
   logic [7:0]  sh_r, sh_nxt;
   logic [7:0]  crc_r, crc_nxt;
   logic [15:0] tmr_r, tmr_nxt;
   logic [15:0] dly_r, dly_nxt;
   logic [3:0]  nfld_r, nfld_nxt;
   logic        line_r, line_nxt;
   logic        dir_r, dir_nxt;
   logic        busy_r, busy_nxt;
   logic        sclk_r, sclk_nxt;
   logic        done_r, done_nxt;
   logic        crce_r, crce_nxt;
   logic        echo_r, echo_nxt;
   logic        toe_r, toe_nxt;
   logic        we;
   logic [7:0]  txb;
   logic [7:0]  req_crc;

   // Sequencer, serialiser, receiver and checksum
   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      bit_nxt   = bit_r;
      fld_nxt   = fld_r;
      len_nxt   = len_r;
      rlen_nxt  = rlen_r;
      f0_nxt    = f0_r;
      f1_nxt    = f1_r;
      f2_nxt    = f2_r;
      f3_nxt    = f3_r;
      sh_nxt    = sh_r;
      crc_nxt   = crc_r;
      tmr_nxt   = tmr_r;
      dly_nxt   = dly_r;
      nfld_nxt  = nfld_r;
      done_nxt  = 1'b0;
      crce_nxt  = crce_r;
      echo_nxt  = echo_r;
      toe_nxt   = 1'b0;
      we        = 1'b0;
      // Request checksum starts from the seed: control, address, then data for a memory write only
      req_crc   = crc_byte(crc_byte(aem_pkg::CRC_INIT, ctrl_field(i_ident)),
                           i_mem_addr);
      if (i_ident == aem_pkg::ID_MEM_WR) begin
         req_crc = crc_byte(req_crc, i_mem_data);
      end
      case (state_r)
         aem_pkg::ST_IDLE: begin
            if (i_start) begin
               state_nxt = aem_pkg::ST_TX;
               f0_nxt    = ctrl_field(i_ident);
               f1_nxt    = i_mem_addr;
               f2_nxt    = (i_ident == aem_pkg::ID_MEM_RD) ? req_crc
                                                           : i_mem_data;
               f3_nxt    = req_crc;
               len_nxt   = req_len(i_ident);
               rlen_nxt  = rsp_len(i_ident);
               cnt_nxt   = 7'h00;
               bit_nxt   = aem_pkg::FLD_START;
               fld_nxt   = 4'h0;
               crce_nxt  = 1'b0;
               echo_nxt  = 1'b0;
               nfld_nxt  = 4'h0;
            end
         end
         aem_pkg::ST_TX: begin
            cnt_nxt = cnt_r + 7'h01;
            if (cnt_r == aem_pkg::BIT_LAST) begin
               cnt_nxt = 7'h00;
               bit_nxt = bit_r + 4'h1;
               if (bit_r == aem_pkg::FLD_DELIM) begin
                  bit_nxt = aem_pkg::FLD_START;
                  fld_nxt = fld_r + 4'h1;
                  if (fld_r == len_r - 4'h1) begin
                     state_nxt = aem_pkg::ST_WAIT;
                     tmr_nxt   = 16'h0000;
                  end
               end
            end
         end
         aem_pkg::ST_WAIT: begin
            tmr_nxt = tmr_r + 16'h0001;
            if (!i_line_data) begin
               // Start edge seen: delay is fixed here, sampling follows it
               state_nxt = aem_pkg::ST_RX;
               dly_nxt   = tmr_r;
               cnt_nxt   = 7'h01;
               bit_nxt   = aem_pkg::FLD_START;
               fld_nxt   = 4'h0;
               crc_nxt   = aem_pkg::CRC_INIT;
            end else if (tmr_r >= i_timeout_cyc) begin
               state_nxt = aem_pkg::ST_IDLE;
               toe_nxt   = 1'b1;
            end
         end
         aem_pkg::ST_RX: begin
            cnt_nxt = cnt_r + 7'h01;
            if (cnt_r == aem_pkg::BIT_LAST) begin
               cnt_nxt = 7'h00;
            end
            // Mid-bit sample, phase anchored to the detected start edge
            if (cnt_r == aem_pkg::BIT_HALF) begin
               bit_nxt = bit_r + 4'h1;
               if (bit_r >= aem_pkg::FLD_PAY0 &&
                   bit_r <= aem_pkg::FLD_PAY7) begin
                  sh_nxt = {i_line_data, sh_r[7:1]};
               end
               if (bit_r == aem_pkg::FLD_DELIM) begin
                  bit_nxt  = aem_pkg::FLD_START;
                  fld_nxt  = fld_r + 4'h1;
                  nfld_nxt = fld_r + 4'h1;
                  we       = 1'b1;
                  if (fld_r == 4'h0 && sh_r != f0_r) begin
                     echo_nxt = 1'b1;
                  end
                  if (fld_r == rlen_r - 4'h1) begin
                     // Last field is the checksum
                     state_nxt = aem_pkg::ST_IDLE;
                     done_nxt  = 1'b1;
                     crce_nxt  = (sh_r != crc_r);
                  end else begin
                     crc_nxt = crc_byte(crc_r, sh_r);
                  end
               end
            end
         end
         default: state_nxt = aem_pkg::ST_IDLE;
      endcase
      // Line drive, direction and gated shift clock
      case (fld_nxt[1:0])
         2'h0:    txb = f0_nxt;
         2'h1:    txb = f1_nxt;
         2'h2:    txb = f2_nxt;
         default: txb = f3_nxt;
      endcase
      dir_nxt  = (state_nxt == aem_pkg::ST_TX);
      busy_nxt = (state_nxt != aem_pkg::ST_IDLE);
      line_nxt = 1'b1;
      if (dir_nxt) begin
         if (bit_nxt == aem_pkg::FLD_START) begin
            line_nxt = 1'b0;
         end else if (bit_nxt <= aem_pkg::FLD_PAY7) begin
            line_nxt = txb[3'(bit_nxt - aem_pkg::FLD_PAY0)];
         end
      end
      sclk_nxt = (state_nxt == aem_pkg::ST_TX ||
                  state_nxt == aem_pkg::ST_RX) &&
                 (cnt_nxt >= aem_pkg::BIT_HALF);
   end

   // State registers
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         state_r <= aem_pkg::ST_IDLE;
         cnt_r   <= 7'h00;
         bit_r   <= 4'h0;
         fld_r   <= 4'h0;
         len_r   <= aem_pkg::REQ_LEN_CTRL;
         rlen_r  <= aem_pkg::RSP_LEN_ABS;
         f0_r    <= 8'h00;
         f1_r    <= 8'h00;
         f2_r    <= 8'h00;
         f3_r    <= 8'h00;
         sh_r    <= 8'h00;
         crc_r   <= aem_pkg::CRC_INIT;
         tmr_r   <= 16'h0000;
         dly_r   <= 16'h0000;
         nfld_r  <= 4'h0;
         line_r  <= 1'b1;
         dir_r   <= 1'b0;
         busy_r  <= 1'b0;
         sclk_r  <= 1'b0;
         done_r  <= 1'b0;
         crce_r  <= 1'b0;
         echo_r  <= 1'b0;
         toe_r   <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         bit_r   <= bit_nxt;
         fld_r   <= fld_nxt;
         len_r   <= len_nxt;
         rlen_r  <= rlen_nxt;
         f0_r    <= f0_nxt;
         f1_r    <= f1_nxt;
         f2_r    <= f2_nxt;
         f3_r    <= f3_nxt;
         sh_r    <= sh_nxt;
         crc_r   <= crc_nxt;
         tmr_r   <= tmr_nxt;
         dly_r   <= dly_nxt;
         nfld_r  <= nfld_nxt;
         line_r  <= line_nxt;
         dir_r   <= dir_nxt;
         busy_r  <= busy_nxt;
         sclk_r  <= sclk_nxt;
         done_r  <= done_nxt;
         crce_r  <= crce_nxt;
         echo_r  <= echo_nxt;
         toe_r   <= toe_nxt;
      end
   end

   // Received payloads, one word per field
   aem_field_mem u_mem (
      .i_sys_clk (i_sys_clk),
      .i_we      (we),
      .i_waddr   (fld_r),
      .i_wdata   (sh_r),
      .i_raddr   (i_rd_idx),
      .o_rdata   (o_rd_data)
   );

   assign o_line_data             = line_r;
   assign o_line_dir_enable       = dir_r;
   assign o_generated_shift_clock = sclk_r;
   assign o_busy                  = busy_r;
   assign o_done                  = done_r;
   assign o_crc_err               = crce_r;
   assign o_echo_err              = echo_r;
   assign o_timeout_err           = toe_r;
   assign o_field_cnt             = nfld_r;
   assign o_prop_delay            = dly_r;

   // Checks
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);

   a_dir_while_tx: assert property (
      dir_r == (state_r == aem_pkg::ST_TX))
      else $error("direction enable not tied to transmit");
   a_clk_gated_idle: assert property (
      state_r == aem_pkg::ST_IDLE |-> !sclk_r)
      else $error("shift clock runs while idle");
   a_start_bit_low: assert property (
      dir_r && bit_r == aem_pkg::FLD_START |-> !line_r)
      else $error("start bit not low");
   a_delim_high: assert property (
      dir_r && bit_r == aem_pkg::FLD_DELIM |-> line_r)
      else $error("delimiter not high");
   a_phase_order: assert property (
      state_r == aem_pkg::ST_IDLE ##1 state_r != aem_pkg::ST_IDLE
      |-> state_r == aem_pkg::ST_TX)
      else $error("idle left for a phase other than transmit");
   a_done_count: assert property (
      done_r |-> nfld_r == rlen_r && state_r == aem_pkg::ST_IDLE)
      else $error("done without full response");
   a_req_length: assert property (
      state_r == aem_pkg::ST_TX ##1 state_r == aem_pkg::ST_WAIT
      |-> fld_r == len_r)
      else $error("request length wrong");
   a_timeout_flag: assert property (
      toe_r |-> $past(state_r) == aem_pkg::ST_WAIT &&
                $past(tmr_r) >= $past(i_timeout_cyc))
      else $error("timeout flag without expiry");
   a_rx_limit: assert property (
      nfld_r <= aem_pkg::RSP_LEN_MAX)
      else $error("too many fields received");
   a_delay_held: assert property (
      state_r == aem_pkg::ST_WAIT && !i_line_data ##1 1
      |-> state_r == aem_pkg::ST_RX && dly_r == $past(tmr_r))
      else $error("propagation delay not captured");

   c_readout: cover property (done_r && !crce_r && rlen_r ==
                              aem_pkg::RSP_LEN_ABS);
   c_full_read: cover property (done_r && rlen_r == aem_pkg::RSP_LEN_ALL);
   c_mem_write: cover property (state_r == aem_pkg::ST_WAIT &&
                                len_r == aem_pkg::REQ_LEN_WR);
   c_timeout: cover property (toe_r);
endmodule

// ==== pkg/aem_pkg.sv ====
// Purpose: Shared constants and types for the encoder serial master
// Assumes: 200 MHz system clock, 2.5 Mbit/s line rate
// Notes:   Field payloads are 8 bits, sent least significant bit first
package aem_pkg;
   // Line timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int BIT_TIME_NS   = 400;
   localparam int BIT_CYC       = (BIT_TIME_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
   localparam logic [6:0] BIT_LAST  = 7'(BIT_CYC - 1);
   localparam logic [6:0] BIT_HALF  = 7'(BIT_CYC / 2);
   // Field framing: start, 8 payload bits, delimiter
   localparam logic [3:0] FLD_START = 4'h0;
   localparam logic [3:0] FLD_PAY0  = 4'h1;
   localparam logic [3:0] FLD_PAY7  = 4'h8;
   localparam logic [3:0] FLD_DELIM = 4'h9;
   // Transaction identifiers
   localparam logic [3:0] ID_ABS    = 4'h0;
   localparam logic [3:0] ID_MULTI  = 4'h1;
   localparam logic [3:0] ID_IDENT  = 4'h2;
   localparam logic [3:0] ID_ALL    = 4'h3;
   localparam logic [3:0] ID_MEM_WR = 4'h6;
   localparam logic [3:0] ID_RST_A  = 4'h7;
   localparam logic [3:0] ID_RST_M  = 4'h8;
   localparam logic [3:0] ID_RST_E  = 4'hC;
   localparam logic [3:0] ID_MEM_RD = 4'hD;
   // Response lengths in fields, checksum included
   localparam logic [3:0] RSP_LEN_ABS   = 4'h6;
   localparam logic [3:0] RSP_LEN_IDENT = 4'h4;
   localparam logic [3:0] RSP_LEN_ALL   = 4'hB;
   localparam logic [3:0] RSP_LEN_MEM   = 4'h4;
   localparam logic [3:0] RSP_LEN_MAX   = 4'hB;
   // Request lengths in fields
   localparam logic [3:0] REQ_LEN_CTRL = 4'h1;
   localparam logic [3:0] REQ_LEN_RD   = 4'h3;
   localparam logic [3:0] REQ_LEN_WR   = 4'h4;
   // Control field layout
   localparam logic [2:0] CTRL_SYNC = 3'h2;
   // Checksum
   localparam logic [7:0] CRC_POLY = 8'h01;
   localparam logic [7:0] CRC_INIT = 8'h00;

   typedef enum logic [1:0] {
      ST_IDLE, ST_TX, ST_WAIT, ST_RX
   } aem_phase_t;
endpackage

// ==== src/aem_field_mem.sv ====
// Purpose: Holds received response field payloads for the host to read
// Assumes: One write and one read per clock
// Notes:   Read data comes out of a register one clock after the address
`timescale 1ns/1ps
module aem_field_mem (
   input  wire logic       i_sys_clk,
   input  wire logic       i_we,
   input  wire logic [3:0] i_waddr,
   input  wire logic [7:0] i_wdata,
   input  wire logic [3:0] i_raddr,
   output logic      [7:0] o_rdata
);
   logic [7:0] mem [16];

   // Storage and registered read port
   always_ff @(posedge i_sys_clk) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
      o_rdata <= mem[i_raddr];
   end
endmodule

// ==== bench/aem_enc_model.sv ====
// Purpose: Behavioural encoder on the far side of the serial line
// Assumes: Bits last 80 clocks; receive line idles high (failsafe)
// Notes:   Bench loads rsp_q and the fault switches before each start
`timescale 1ns/1ps
module aem_enc_model (
   input  wire logic i_sys_clk,
   input  wire logic i_tx_line,
   input  wire logic i_dir,
   output logic      o_rx_line
);
   logic [7:0] rsp_q[$];
   logic [7:0] req_q[$];
   int         dly;
   int         frame_errs;
   bit         bad_crc;
   bit         bad_echo;
   bit         silent;

   // One checksum step over a payload byte, low bit first
   function automatic logic [7:0] crc_add(input logic [7:0] c,
                                          input logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         c = (c[7] ^ b[i]) ? {c[6:0], 1'b0} ^ aem_pkg::CRC_POLY
                           : {c[6:0], 1'b0};
      end
      return c;
   endfunction

   // Send one field: start, payload low bit first, delimiter
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         o_rx_line = f[i];
         repeat (80) @(negedge i_sys_clk);
      end
   endtask

   // Capture request fields mid-bit, then answer after the cable delay
   initial begin
      logic [9:0] f;
      logic [7:0] crc;
      o_rx_line = 1'b1;
      forever begin
         @(negedge i_sys_clk);
         if (i_dir) begin
            req_q = {};
            while (i_dir) begin
               for (int i = 0; i < 10; i++) begin
                  repeat (i == 0 ? 40 : 80) @(negedge i_sys_clk);
                  f[i] = i_tx_line;
               end
               if (f[0] || !f[9]) frame_errs++;
               req_q.push_back(f[8:1]);
               repeat (40) @(negedge i_sys_clk);
            end
            if (!silent) begin
               repeat (dly) @(negedge i_sys_clk);
               crc = bad_echo ? ~req_q[0] : req_q[0];
               rsp_q.push_front(crc);
               crc = aem_pkg::CRC_INIT;
               foreach (rsp_q[k]) begin
                  send(rsp_q[k]);
                  crc = crc_add(crc, rsp_q[k]);
               end
               send(bad_crc ? ~crc : crc);
               o_rx_line = 1'b1;
            end
         end
      end
   end
endmodule

// ==== bench/aem_master_tb.sv ====
// Purpose: Self-checking bench for the encoder serial master
// Assumes: Encoder model answers on a line that idles high
// Notes:   Expected fields and checksums are rebuilt in the bench
`timescale 1ns/1ps
module aem_master_tb;
   logic        i_sys_clk;
   logic        i_rst;
   logic        i_start;
   logic [3:0]  i_ident;
   logic [7:0]  i_mem_addr;
   logic [7:0]  i_mem_data;
   logic [15:0] i_timeout_cyc;
   logic [3:0]  i_rd_idx;
   logic        rx_line;
   logic        tx_line;
   logic        dir;
   logic        sclk;
   logic        o_busy;
   logic        o_done;
   logic        o_crc_err;
   logic        o_echo_err;
   logic        o_timeout_err;
   logic [3:0]  o_field_cnt;
   logic [15:0] o_prop_delay;
   logic [7:0]  o_rd_data;
   logic        sclk_q;
   int          failures;
   int          cmp_count;
   int          tx_cyc;
   int          tx_rise;
   int          rx_rise;
   int          wait_cyc;
   logic [3:0]  ids[9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6,
                           4'h7, 4'h8, 4'hC, 4'hD};

   aem_master dut_u (
      .i_sys_clk              (i_sys_clk),
      .i_rst                  (i_rst),
      .i_start                (i_start),
      .i_ident                (i_ident),
      .i_mem_addr             (i_mem_addr),
      .i_mem_data             (i_mem_data),
      .i_timeout_cyc          (i_timeout_cyc),
      .i_rd_idx               (i_rd_idx),
      .i_line_data            (rx_line),
      .o_line_data            (tx_line),
      .o_line_dir_enable      (dir),
      .o_generated_shift_clock(sclk),
      .o_busy                 (o_busy),
      .o_done                 (o_done),
      .o_crc_err              (o_crc_err),
      .o_echo_err             (o_echo_err),
      .o_timeout_err          (o_timeout_err),
      .o_field_cnt            (o_field_cnt),
      .o_prop_delay           (o_prop_delay),
      .o_rd_data              (o_rd_data)
   );

   aem_enc_model enc_u (
      .i_sys_clk(i_sys_clk),
      .i_tx_line(tx_line),
      .i_dir    (dir),
      .o_rx_line(rx_line)
   );

   // 200 MHz clock
   initial begin
      i_sys_clk = 1'b0;
      forever #2.5 i_sys_clk = ~i_sys_clk;
   end

   // Count drive cycles, shift clock edges and wait span per transaction
   always @(posedge i_sys_clk) begin
      if (i_start && !o_busy) begin
         tx_cyc = 0;
         tx_rise = 0;
         rx_rise = 0;
         wait_cyc = 0;
      end else if (o_busy) begin
         tx_cyc += dir;
         tx_rise += (sclk && !sclk_q && dir);
         rx_rise += (sclk && !sclk_q && !dir);
         wait_cyc += (!dir && rx_line);
      end
      sclk_q = sclk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("checks=%0d failures=%0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // One transaction: load the model, start, wait, compare results (no response checks when silent)
   task automatic run(input logic [3:0] id, input int dly, input bit bc,
                      input bit be, input bit sil, input bit dbl);
      logic [7:0] exp_q[$];
      logic [7:0] ctl;
      logic [7:0] crc;
      logic       mem;
      int         n;
      int         rq;
      mem = (id == aem_pkg::ID_MEM_WR) || (id == aem_pkg::ID_MEM_RD);
      n = (id == 4'h2) ? 2 : (id == 4'h3) ? 9 : mem ? 2 : 4;
      rq = (id == 4'h6) ? 4 : (id == 4'hD) ? 3 : 1;
      ctl = {^id, id, aem_pkg::CTRL_SYNC};
      i_mem_addr = 8'($urandom);
      i_mem_data = 8'($urandom);
      enc_u.rsp_q = {};
      for (int i = 0; i < n; i++) begin
         enc_u.rsp_q.push_back(8'($urandom));
      end
      if (mem) enc_u.rsp_q[0] = i_mem_addr;
      if (id == 4'h6) enc_u.rsp_q[1] = i_mem_data;
      exp_q = enc_u.rsp_q;
      exp_q.push_front(be ? ~ctl : ctl);
      enc_u.dly = dly;
      enc_u.bad_crc = bc;
      enc_u.bad_echo = be;
      enc_u.silent = sil;
      enc_u.frame_errs = 0;
      i_timeout_cyc = sil ? 16'h012C : 16'h07D0;
      i_ident = id;
      i_start = 1'b1;
      @(negedge i_sys_clk);
      i_start = 1'b0;
      if (dbl) begin
         repeat (100) @(negedge i_sys_clk);
         i_ident = 4'h3;
         i_start = 1'b1;
         @(negedge i_sys_clk);
         i_start = 1'b0;
      end
      for (int w = 0; w < 20000 && !o_done && !o_timeout_err; w++) begin
         @(negedge i_sys_clk);
      end
      crc = enc_u.crc_add(enc_u.crc_add(aem_pkg::CRC_INIT, ctl), i_mem_addr);
      if (id == 4'h6) crc = enc_u.crc_add(crc, i_mem_data);
      check(o_done, !sil);
      check(o_timeout_err, sil);
      check(enc_u.req_q.size(), rq);
      check(enc_u.req_q[0], ctl);
      check(enc_u.frame_errs, 0);
      check(tx_cyc, rq * 800);
      check(tx_rise, rq * 10);
      if (mem) check(enc_u.req_q[1], i_mem_addr);
      if (id == 4'h6) check(enc_u.req_q[2], i_mem_data);
      if (mem) check(enc_u.req_q[rq - 1], crc);
      if (sil) begin
         check(wait_cyc >= 300 && wait_cyc <= 304, 1);
      end else begin
         check(o_crc_err, bc);
         check(o_echo_err, be);
         check(o_field_cnt, n + 2);
         check(o_prop_delay >= dly && o_prop_delay <= dly + 4, 1);
         check(rx_rise >= 10 * n + 18 && rx_rise <= 10 * n + 20, 1);
         for (int i = 0; i <= n; i++) begin
            i_rd_idx = 4'(i);
            @(negedge i_sys_clk);
            check(o_rd_data, exp_q[i]);
         end
      end
      // Model still holds the last delimiter; let it return to listening
      repeat (60) @(negedge i_sys_clk);
   endtask

   // Main sequence
   initial begin
      i_rst = 1'b1;
      i_start = 1'b0;
      i_ident = 4'h0;
      i_mem_addr = 8'h00;
      i_mem_data = 8'h00;
      i_timeout_cyc = 16'h07D0;
      i_rd_idx = 4'h0;
      failures = 0;
      cmp_count = 0;
      void'($urandom(32'hCEFF));
      repeat (2) @(negedge i_sys_clk);
      i_rst = 1'b0;
      check({tx_line, dir, sclk, o_busy}, 4'h8);
      foreach (ids[k]) begin
         run(ids[k], 2 + $urandom % 200, 0, 0, 0, 0);
      end
      run(4'h3, 1500, 1, 0, 0, 0);
      run(4'h0, 5, 0, 1, 0, 0);
      run(4'h1, 20, 0, 0, 1, 0);
      run(4'hD, 30, 0, 0, 0, 1);
      // Reset in the middle of a request
      enc_u.silent = 1'b1;
      i_ident = 4'h6;
      i_start = 1'b1;
      @(negedge i_sys_clk);
      i_start = 1'b0;
      repeat (500) @(negedge i_sys_clk);
      i_rst = 1'b1;
      @(negedge i_sys_clk);
      check({tx_line, dir, sclk, o_busy}, 4'h8);
      i_rst = 1'b0;
      repeat (3000) @(negedge i_sys_clk);
      run(4'h2, 10, 0, 0, 0, 0);
      results();
   end

   // Watchdog
   initial begin
      // About 96000 clocks, a little above the expected run length
      #480000;
      failures++;
      results();
   end
endmodule
